// file: fbw_defines.svh
// constant names for the flash block write controller
`ifndef FBW_DEFINES_SVH
`define FBW_DEFINES_SVH
// register indexes, byte address is four times the index
`define FBW_IDX_FLAGS2 12'h00d
`define FBW_IDX_ENABLES2 12'h08d
`define FBW_IDX_DATA_LO 12'h10c
`define FBW_IDX_ADDR_LO 12'h10d
`define FBW_IDX_DATA_HI 12'h10e
`define FBW_IDX_ADDR_HI 12'h10f
`define FBW_IDX_CTRL1 12'h18c
`define FBW_IDX_UNLOCK 12'h18d
`define FBW_IDX_INTCTRL 12'h1f0
// bit positions
`define FBW_BIT_PGD 7
`define FBW_BIT_WRITE_ERROR_FLAG 3
`define FBW_BIT_WRITE_ENABLE_BIT 2
`define FBW_BIT_WR 1
`define FBW_BIT_FLAG 4
`define FBW_BIT_IE 4
`define FBW_BIT_PERIPHERAL_GLOBAL_INT_ENABLE 6
// unlock values and word positions
`define FBW_UNLOCK_A 8'h55
`define FBW_UNLOCK_B 8'haa
`define FBW_WORD_FIRST 2'b00
`define FBW_WORD_LAST 2'b11
// bus answers
`define FBW_RESP_OKAY 2'b00
`define FBW_RESP_SLVERR 2'b10
// timing figures
`define FBW_CLK_NS 8
`define FBW_WRITE_NS 4000000
`define FBW_PWRT_NS 72000000
`define FBW_SETUP_CYC 2
`endif

// file: fbw_pkg.sv
// types shared by the flash block write controller
package fbw_pkg;
  // controller sequencing states
  typedef enum logic [2:0] {
    FBW_IDLE,
    FBW_SETUP,
    FBW_ERASE,
    FBW_PROG,
    FBW_DONE
  } fbw_state_e;
  // command toward the flash array
  typedef struct packed {
    logic erase;
    logic prog;
    logic [12:0] addr;
    logic [13:0] data;
  } fbw_flash_cmd_s;
endpackage

// file: fbw_buf.sv
// four word write buffer with registered read port
`timescale 1ns/1ns
module fbw_buf #(
  parameter int W = 14,
  parameter int D = 4
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [$clog2(D)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(D)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D]; // word storage, no reset needed
  // write port
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read port
  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end
endmodule // fbw_buf

// file: fbw_ctrl.sv
// flash block write controller with axi4-lite registers
// How it works
// - write-protected segments refuse the write
// - blocks are four words, base low bits 00
// - each block is erased then programmed
// - select bit, 55h, AAh, then start bit
// - last word triggers erase and program
// - two setup cycles follow the start bit
// - first three words only fill buffer
// - processor stalls about 4 ms during write
// - execution resumes after the stall ends
// - out of sequence targets are ignored
// - write enable clears at power-up
// - power-up timer blocks writes for 72 ms
// - start needs enable and completed unlock
// - data code protect blocks external access
// - program protect blocks external program writes
// - unlock port holds no storage
// - enable bit 4 gates completion interrupt
// - global peripheral enable gates all
`timescale 1ns/1ns
`include "fbw_defines.svh"
module fbw_ctrl import fbw_pkg::*; #(
  parameter int WRITE_CYCLES = `FBW_WRITE_NS / `FBW_CLK_NS,
  parameter int PWRT_CYCLES = `FBW_PWRT_NS / `FBW_CLK_NS,
  parameter logic [12:0] PROT_LOW_END = 13'h0100,
  parameter logic [12:0] PROT_HALF = 13'h1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] flash_protect_config_bits,
  input wire logic [1:0] region_inhibit_config_bits,
  input wire logic code_protect_data,
  input wire logic code_protect_prog,
  input wire logic soft_reset,
  output fbw_flash_cmd_s flash_cmd,
  output logic cpu_stall,
  output logic peripheral_irq,
  output logic pwrt_running,
  output logic ext_data_access_enable,
  output logic ext_prog_write_enable
);
  // true when a program address may be written under given bits
  function automatic logic prot_ok(input logic [12:0] a,
                                   input logic [1:0] bits);
    case (bits)
      2'b11: prot_ok = 1'b1;
      2'b10: prot_ok = (a >= PROT_LOW_END);
      2'b01: prot_ok = (a >= PROT_HALF);
      default: prot_ok = 1'b0;
    endcase
  endfunction

  // register state
  logic [7:0] data_lo; // nvm_data_low
  logic [7:0] addr_lo; // nvm_address_low
  logic [5:0] data_hi; // nvm_data_high
  logic [4:0] addr_hi; // nvm_address_high
  logic program_memory_select;
  logic write_error_flag;
  logic write_enable_bit;
  logic wr_bit; // write-start bit
  logic write_complete_flag;
  logic write_complete_int_enable;
  logic peripheral_global_int_enable;
  // bus side holding registers
  logic aw_got, w_got;
  logic [11:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  // sequencing
  fbw_state_e state;
  logic [1:0] unlock_stage; // 0 none, 1 saw 55h, 2 unlocked
  logic [1:0] exp_idx; // next expected word in block
  logic [10:0] blk_base; // block of the words taken so far
  logic pend_legal, pend_last;
  logic [$clog2(WRITE_CYCLES+1)-1:0] busy_cnt;
  logic [1:0] setup_cnt;
  logic [2:0] prog_idx;
  logic [$clog2(PWRT_CYCLES+1)-1:0] pwrt_cnt;
  logic [13:0] buf_rdata;

  // combinational decode of a completed bus write
  logic wr_fire;
  logic [12:0] full_addr;
  logic [1:0] word_idx;
  logic start_req, start_ok, word_legal;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign full_addr = {addr_hi, addr_lo};
  assign word_idx = addr_lo[1:0];
  assign start_req = wr_fire && w_lane0 && aw_idx == `FBW_IDX_CTRL1
                     && w_byte[`FBW_BIT_WR] && !wr_bit;
  // start needs enable, unlock, select bit, idle, timer done
  assign start_ok = start_req && write_enable_bit
                    && unlock_stage == 2'd2
                    && w_byte[`FBW_BIT_PGD] && state == FBW_IDLE
                    && !pwrt_running;
  // word must follow in order inside one unprotected block
  assign word_legal = word_idx == exp_idx
                      && (word_idx == `FBW_WORD_FIRST
                          || full_addr[12:2] == blk_base)
                      && prot_ok(full_addr,
                                 flash_protect_config_bits)
                      && prot_ok(full_addr,
                                 region_inhibit_config_bits);

  // write buffer, loaded on each legal word
  fbw_buf #(.W(14), .D(4)) u_buf (
    .aclk(aclk),
    .we(start_ok && word_legal),
    .waddr(word_idx),
    .wdata({data_hi, data_lo}),
    .raddr(prog_idx[1:0]),
    .rdata(buf_rdata)
  );

  // axi write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 12'h000;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // ready pulses for one cycle when a beat is taken
      s_axi_awready <= !aw_got && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_got && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_idx <= s_axi_awaddr[13:2];
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end
    end
  end

  // write response, slverr on unmapped index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FBW_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_idx) ? `FBW_RESP_OKAY : `FBW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // true for indexes that hold a register
  function automatic logic mapped(input logic [11:0] i);
    case (i)
      `FBW_IDX_FLAGS2, `FBW_IDX_ENABLES2, `FBW_IDX_DATA_LO,
      `FBW_IDX_ADDR_LO, `FBW_IDX_DATA_HI, `FBW_IDX_ADDR_HI,
      `FBW_IDX_CTRL1, `FBW_IDX_UNLOCK, `FBW_IDX_INTCTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // read channel, answer one cycle after address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FBW_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr[13:2]) ? `FBW_RESP_OKAY
                                                   : `FBW_RESP_SLVERR;
        case (s_axi_araddr[13:2])
          `FBW_IDX_FLAGS2:
            s_axi_rdata <= {27'h0, write_complete_flag, 4'h0};
          `FBW_IDX_ENABLES2:
            s_axi_rdata <= {27'h0, write_complete_int_enable, 4'h0};
          `FBW_IDX_DATA_LO: s_axi_rdata <= {24'h0, data_lo};
          `FBW_IDX_ADDR_LO: s_axi_rdata <= {24'h0, addr_lo};
          `FBW_IDX_DATA_HI: s_axi_rdata <= {26'h0, data_hi};
          `FBW_IDX_ADDR_HI: s_axi_rdata <= {27'h0, addr_hi};
          `FBW_IDX_CTRL1:
            s_axi_rdata <= {24'h0, program_memory_select, 3'h0,
                            write_error_flag, write_enable_bit, wr_bit, 1'b0};
          `FBW_IDX_INTCTRL:
            s_axi_rdata <= {25'h0, peripheral_global_int_enable, 6'h0};
          default: s_axi_rdata <= 32'h0000_0000; // unlock port reads zero
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // address and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_lo <= 8'h00;
      addr_lo <= 8'h00;
      data_hi <= 6'h00;
      addr_hi <= 5'h00;
    end else if (wr_fire && w_lane0) begin
      case (aw_idx)
        `FBW_IDX_DATA_LO: data_lo <= w_byte;
        `FBW_IDX_ADDR_LO: addr_lo <= w_byte;
        `FBW_IDX_DATA_HI: data_hi <= w_byte[5:0];
        `FBW_IDX_ADDR_HI: addr_hi <= w_byte[4:0];
        default: ;
      endcase
    end
  end

  // unlock tracker, the port itself stores nothing
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      unlock_stage <= 2'd0;
    end else if (wr_fire && w_lane0) begin
      if (aw_idx == `FBW_IDX_UNLOCK) begin
        if (w_byte == `FBW_UNLOCK_A) begin
          unlock_stage <= 2'd1;
        end else if (w_byte == `FBW_UNLOCK_B && unlock_stage == 2'd1) begin
          unlock_stage <= 2'd2;
        end else begin
          unlock_stage <= 2'd0;
        end
      end else if (aw_idx == `FBW_IDX_CTRL1) begin
        unlock_stage <= 2'd0; // each start consumes the unlock
      end
    end
  end

  // control register 1 bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_memory_select <= 1'b0;
      write_enable_bit <= 1'b0;
      write_error_flag <= 1'b0;
      wr_bit <= 1'b0;
    end else if (soft_reset) begin
      write_enable_bit <= 1'b0;
      wr_bit <= 1'b0;
      // a soft reset that cuts a write short marks the error
      if (state != FBW_IDLE) begin
        write_error_flag <= 1'b1;
      end
    end else begin
      if (wr_fire && w_lane0 && aw_idx == `FBW_IDX_CTRL1) begin
        program_memory_select <= w_byte[`FBW_BIT_PGD];
        write_enable_bit <= w_byte[`FBW_BIT_WRITE_ENABLE_BIT];
        write_error_flag <= w_byte[`FBW_BIT_WRITE_ERROR_FLAG];
      end
      // start bit is set by software, cleared only by hardware
      if (start_ok) begin
        wr_bit <= 1'b1;
      end else if (state == FBW_DONE) begin
        wr_bit <= 1'b0;
      end
    end
  end

  // block sequence tracking
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      exp_idx <= `FBW_WORD_FIRST;
      blk_base <= 11'h000;
      pend_legal <= 1'b0;
      pend_last <= 1'b0;
    end else if (start_ok) begin
      pend_legal <= word_legal;
      pend_last <= word_legal && word_idx == `FBW_WORD_LAST;
      if (word_legal) begin
        exp_idx <= word_idx + 2'd1; // wraps to first after last
        blk_base <= full_addr[12:2];
      end else begin
        exp_idx <= `FBW_WORD_FIRST;
      end
    end
  end

  // main sequencer: setup, erase, program, done
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      state <= FBW_IDLE;
      setup_cnt <= 2'd0;
      busy_cnt <= '0;
      prog_idx <= 3'd0;
    end else begin
      case (state)
        FBW_IDLE: begin
          if (start_ok) begin
            state <= FBW_SETUP;
            setup_cnt <= 2'd0;
          end
        end
        FBW_SETUP: begin
          setup_cnt <= setup_cnt + 2'd1;
          if (setup_cnt == 2'(`FBW_SETUP_CYC - 1)) begin
            // only a legal last word goes on to erase
            state <= pend_last ? FBW_ERASE : FBW_DONE;
            busy_cnt <= '0;
          end
        end
        FBW_ERASE: begin
          busy_cnt <= busy_cnt + 1'b1;
          if (busy_cnt == $bits(busy_cnt)'(WRITE_CYCLES - 1)) begin
            state <= FBW_PROG;
            prog_idx <= 3'd0;
          end
        end
        FBW_PROG: begin
          prog_idx <= prog_idx + 3'd1;
          if (prog_idx == 3'd4) begin
            state <= FBW_DONE;
          end
        end
        FBW_DONE: state <= FBW_IDLE;
        default: state <= FBW_IDLE;
      endcase
    end
  end

  // flash array commands, erase a one cycle pulse, prog high one cycle per word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.erase <= state == FBW_SETUP && pend_last
                         && setup_cnt == 2'(`FBW_SETUP_CYC - 1);
      // buffer data arrive one cycle after the read index
      flash_cmd.prog <= state == FBW_PROG && prog_idx != 3'd0;
      flash_cmd.addr <= {blk_base, 2'(prog_idx - 3'd1)};
      flash_cmd.data <= buf_rdata;
    end
  end

  // processor stall, held through erase and program only
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      cpu_stall <= 1'b0;
    end else begin
      // release after the last word lets execution resume
      cpu_stall <= (state == FBW_SETUP && pend_last
                    && setup_cnt == 2'(`FBW_SETUP_CYC - 1))
                   || state == FBW_ERASE
                   || state == FBW_PROG;
    end
  end

  // completion flag: hardware set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_complete_flag <= 1'b0;
    end else if (state == FBW_DONE && pend_last) begin
      write_complete_flag <= 1'b1;
    end else if (wr_fire && w_lane0 && aw_idx == `FBW_IDX_FLAGS2) begin
      write_complete_flag <= w_byte[`FBW_BIT_FLAG];
    end
  end

  // interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_complete_int_enable <= 1'b0;
      peripheral_global_int_enable <= 1'b0;
    end else if (wr_fire && w_lane0) begin
      if (aw_idx == `FBW_IDX_ENABLES2) begin
        write_complete_int_enable <= w_byte[`FBW_BIT_IE];
      end
      if (aw_idx == `FBW_IDX_INTCTRL) begin
        peripheral_global_int_enable <= w_byte[`FBW_BIT_PERIPHERAL_GLOBAL_INT_ENABLE];
      end
    end
  end

  // interrupt request toward the processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_irq <= 1'b0;
    end else begin
      peripheral_irq <= write_complete_flag
                        && write_complete_int_enable
                        && peripheral_global_int_enable;
    end
  end

  // power-up timer, runs once after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwrt_cnt <= '0;
      pwrt_running <= 1'b1;
    end else if (pwrt_running) begin
      pwrt_cnt <= pwrt_cnt + 1'b1;
      if (pwrt_cnt == $bits(pwrt_cnt)'(PWRT_CYCLES - 1)) begin
        pwrt_running <= 1'b0;
      end
    end
  end

  // external access gates under code protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_data_access_enable <= 1'b0;
      ext_prog_write_enable <= 1'b0;
    end else begin
      ext_data_access_enable <= !code_protect_data;
      ext_prog_write_enable <= !code_protect_data
                               && !code_protect_prog;
    end
  end
endmodule // fbw_ctrl

// file: fbw_flash_model.sv
// behavioural flash array behind the block write controller
`timescale 1ns/1ns
module fbw_flash_model import fbw_pkg::*; (
  input wire logic aclk,
  input wire fbw_flash_cmd_s flash_cmd,
  output int erase_count
);
  logic [13:0] mem [logic [12:0]]; // stored words, absent means unknown
  initial erase_count = 0;
  // erase whole block, program ands into cells like real flash
  always @(posedge aclk) begin
    if (flash_cmd.erase) begin
      for (int i = 0; i < 4; i++) begin
        mem[{flash_cmd.addr[12:2], 2'(i)}] = 14'h3fff;
      end
      erase_count++;
    end
    if (flash_cmd.prog) begin
      if (mem.exists(flash_cmd.addr)) begin
        mem[flash_cmd.addr] = mem[flash_cmd.addr] & flash_cmd.data;
      end else begin
        mem[flash_cmd.addr] = 14'h0; // unerased cell gives garbage
      end
    end
  end
endmodule // fbw_flash_model

// file: fbw_ctrl_asserts.sv
// port checker for the flash block write controller
`timescale 1ns/1ns
module fbw_ctrl_asserts import fbw_pkg::*; #(
  parameter int WRITE_CYCLES = 20,
  parameter int PWRT_CYCLES = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic code_protect_data,
  input wire logic code_protect_prog,
  input wire fbw_flash_cmd_s flash_cmd,
  input wire logic cpu_stall,
  input wire logic peripheral_irq,
  input wire logic pwrt_running,
  input wire logic ext_data_access_enable,
  input wire logic ext_prog_write_enable
);
  logic [31:0] stall_cnt; // stalled cycles so far
  logic [31:0] since_rst; // cycles since reset release
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // count the current stall
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_stall) begin
      stall_cnt <= '0;
    end else begin
      stall_cnt <= stall_cnt + 32'h1;
    end
  end
  // count from reset, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_rst <= '0;
    end else if (~&since_rst) begin
      since_rst <= since_rst + 32'h1;
    end
  end
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ready_pulse:
    assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_erase_pulse:
    assert property (flash_cmd.erase |=> !flash_cmd.erase)
    else $error("erase not a single pulse");
  a_prog_stalled:
    assert property (flash_cmd.prog |-> cpu_stall)
    else $error("program without stall");
  a_stall_min:
    assert property ($rose(cpu_stall) |-> cpu_stall [*8])
    else $error("stall too short");
  a_stall_bound:
    assert property (cpu_stall |-> stall_cnt < WRITE_CYCLES + 6)
    else $error("stall too long");
  a_pwrt_hold:
    assert property (since_rst + 32'h1 < PWRT_CYCLES |-> pwrt_running)
    else $error("power-up timer ended early");
  a_pwrt_quiet:
    assert property (pwrt_running |-> !flash_cmd.erase && !flash_cmd.prog)
    else $error("flash write during power-up");
  a_ext_data:
    assert property ($past(aresetn) |->
      ext_data_access_enable == !$past(code_protect_data))
    else $error("external data access wrong");
  a_ext_prog:
    assert property ($past(aresetn) |-> ext_prog_write_enable ==
      !($past(code_protect_data) || $past(code_protect_prog)))
    else $error("external program write wrong");
  c_stall: cover property ($rose(cpu_stall));
  c_prog: cover property (flash_cmd.prog);
  c_irq: cover property (peripheral_irq);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // fbw_ctrl_asserts

// file: flash_block_write_ctrl_test.sv
// self-checking bench for the flash block write controller
`timescale 1ns/1ns
`include "fbw_defines.svh"
module flash_block_write_ctrl_test import fbw_pkg::*;;
  localparam int WC = 20; // shortened write time
  localparam int PW = 12; // shortened power-up time
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [1:0] fpc = 2'b11, ric = 2'b11; // protect configs
  logic cpd = 0, cpp = 0, srst = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic stall, irq, pwrt, ext_d, ext_p;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  fbw_flash_cmd_s cmd;
  int erases, stall_cyc, bad_count = 0, compares = 0;
  always #4 aclk = ~aclk; // 125 MHz
  fbw_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PW)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_protect_config_bits(fpc),
    .region_inhibit_config_bits(ric), .code_protect_data(cpd),
    .code_protect_prog(cpp), .soft_reset(srst), .flash_cmd(cmd),
    .cpu_stall(stall), .peripheral_irq(irq), .pwrt_running(pwrt),
    .ext_data_access_enable(ext_d), .ext_prog_write_enable(ext_p));
  fbw_flash_model fm (.aclk(aclk), .flash_cmd(cmd), .erase_count(erases));
  // stalled cycles since last clear
  always @(posedge aclk) if (stall) stall_cyc <= stall_cyc + 1;
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // bus write: address and data together, hold each until taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      n++;
    end while (!bvalid && n < 100);
    if (!bvalid) bad_count++; // write never answered
    r = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic w(input logic [11:0] idx, input logic [7:0] d);
    wr(idx, d, rs);
    chk(rs, `FBW_RESP_OKAY);
  endtask
  // bus read, rready held until data arrives
  task automatic rd(input logic [11:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      n++;
    end while (!rvalid && n < 100);
    if (!rvalid) bad_count++; // read never answered
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [11:0] idx, input logic [31:0] m, e);
    rd(idx, rv, rs);
    chk(rv & m, e);
  endtask
  function automatic logic [13:0] dat(input logic [12:0] a);
    return {a[12:7], a[7:0] ^ 8'h3c};
  endfunction
  // one word: address, data, select, unlock, start
  task automatic flash_word(input logic [12:0] a, input bit unl);
    logic [13:0] d;
    d = dat(a);
    w(`FBW_IDX_ADDR_LO, a[7:0]);
    w(`FBW_IDX_ADDR_HI, {3'h0, a[12:8]});
    w(`FBW_IDX_DATA_LO, d[7:0]);
    w(`FBW_IDX_DATA_HI, {2'h0, d[13:8]});
    w(`FBW_IDX_CTRL1, 8'h84);
    if (unl) begin
      w(`FBW_IDX_UNLOCK, `FBW_UNLOCK_A);
      w(`FBW_IDX_UNLOCK, `FBW_UNLOCK_B);
    end
    w(`FBW_IDX_CTRL1, 8'h86);
  endtask
  // four words in order; ok says whether the block lands
  task automatic block(input logic [12:0] b, input bit unl, ok);
    int e;
    e = erases;
    for (int i = 0; i < 4; i++) begin
      stall_cyc = 0;
      flash_word(b + 13'(i), i != 3 || unl);
      repeat (i == 3 ? WC + 15 : 6) @(posedge aclk);
      chk(stall_cyc, (i == 3 && ok) ? WC + 6 : 0);
      rc(`FBW_IDX_CTRL1, 32'h02, 32'h0);
    end
    chk(erases, e + (ok ? 1 : 0));
    for (int i = 0; i < 4 && ok; i++) begin
      chk(fm.mem[b + 13'(i)], dat(b + 13'(i)));
    end
    rc(`FBW_IDX_FLAGS2, 32'hff, ok ? 32'h10 : 32'h0);
  endtask
  task final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    chk_pin(pwrt, 1);
    @(posedge aclk);
    rc(`FBW_IDX_FLAGS2, 32'hff, 32'h0);
    rc(`FBW_IDX_ENABLES2, 32'hff, 32'h0);
    rc(`FBW_IDX_CTRL1, 32'h0e, 32'h0);
    wr(12'h300, 8'h01, rs);
    chk(rs, `FBW_RESP_SLVERR);
    rd(12'h300, rv, rs);
    chk(rs, `FBW_RESP_SLVERR);
    w(`FBW_IDX_ADDR_HI, 8'hff);
    rc(`FBW_IDX_ADDR_HI, 32'hff, 32'h1f);
    w(`FBW_IDX_DATA_HI, 8'hff);
    rc(`FBW_IDX_DATA_HI, 32'hff, 32'h3f);
    for (int n = 0; n < 100 && pwrt; n++) @(posedge aclk);
    chk_pin(pwrt, 0);
    block(13'h040, 1, 1);
    w(`FBW_IDX_ENABLES2, 8'h10);
    repeat (3) @(posedge aclk);
    chk_pin(irq, 0);
    w(`FBW_IDX_INTCTRL, 8'h40);
    repeat (3) @(posedge aclk);
    chk_pin(irq, 1);
    w(`FBW_IDX_FLAGS2, 8'h00);
    repeat (3) @(posedge aclk);
    chk_pin(irq, 0);
    block(13'h0a0, 0, 0);
    // last word of another block while word 11 is expected
    stall_cyc = 0;
    flash_word(13'h083, 1);
    repeat (WC + 15) @(posedge aclk);
    chk(stall_cyc, 0);
    chk(erases, 1);
    for (int k = 0; k < 2; k++) begin
      fpc <= k ? 2'b11 : 2'b10;
      ric <= k ? 2'b10 : 2'b11;
      block(13'h044, 1, 0);
    end
    fpc <= 2'b11;
    ric <= 2'b11;
    for (int i = 0; i < 4; i++) flash_word(13'h0c0 + 13'(i), 1);
    repeat (12) @(posedge aclk);
    srst <= 1;
    @(posedge aclk);
    srst <= 0;
    repeat (WC + 15) @(posedge aclk);
    chk_pin(stall, 0);
    rc(`FBW_IDX_CTRL1, 32'h0a, 32'h08);
    cpd <= 1;
    repeat (2) @(posedge aclk);
    chk_pin(ext_d, 0);
    chk_pin(ext_p, 0);
    cpd <= 0;
    cpp <= 1;
    repeat (2) @(posedge aclk);
    chk_pin(ext_d, 1);
    chk_pin(ext_p, 0);
    final_report;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report;
  end
endmodule // flash_block_write_ctrl_test
bind fbw_ctrl fbw_ctrl_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .code_protect_data(code_protect_data),
  .code_protect_prog(code_protect_prog), .flash_cmd(flash_cmd),
  .cpu_stall(cpu_stall), .peripheral_irq(peripheral_irq),
  .pwrt_running(pwrt_running),
  .ext_data_access_enable(ext_data_access_enable),
  .ext_prog_write_enable(ext_prog_write_enable));
